// >>> verilog/ccr_pkg.sv
// package: register map, field layout and encodings of the clock config slice
`default_nettype none
package ccr_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFF_AHB_RST  = 8'h28;
    localparam logic [7:0] OFF_CFG1     = 8'h2C;
    localparam logic [7:0] OFF_DSV      = 8'h34;
    // offset of the shared bit's other home (config register zero, not held here)
    localparam logic [7:0] OFF_CFG0     = 8'h04;
    // ==========================================
    // reset values
    localparam logic [31:0] RST_AHB_RST = 32'h0000_0000;
    localparam logic [31:0] RST_CFG1    = 32'h0000_0000;
    localparam logic [31:0] RST_DSV     = 32'h0000_0000;
    // ==========================================
    // writable bit masks, reserved bits stay zero
    localparam logic [31:0] MASK_AHB_RST = 32'h0000_1000;
    localparam logic [31:0] MASK_CFG1    = 32'h6007_FFFF;
    localparam logic [31:0] MASK_DSV     = 32'h0000_0003;
    // ==========================================
    // field positions
    localparam int USB_RST_BIT   = 12;
    localparam int PLL_SEL_BIT   = 30;
    localparam int ADC_PSC_BIT   = 29;
    localparam int AUD2_SEL_BIT  = 18;
    localparam int AUD1_SEL_BIT  = 17;
    localparam int PDIV0_SEL_BIT = 16;
    localparam int PLL3_MF_LSB   = 12;
    localparam int PLL2_MF_LSB   = 8;
    localparam int PDIV1_LSB     = 4;
    localparam int PDIV0_LSB     = 0;
    localparam int CFG0_PDIV_BIT = 17;
    // ==========================================
    // deep sleep voltage codes, in millivolts
    localparam logic [1:0] DSV_1V0 = 2'h0;
    localparam logic [1:0] DSV_0V9 = 2'h1;
    localparam logic [1:0] DSV_0V8 = 2'h2;
    localparam logic [1:0] DSV_1V2 = 2'h3;
    localparam logic [10:0] MV_1V0 = 11'h3E8;
    localparam logic [10:0] MV_0V9 = 11'h384;
    localparam logic [10:0] MV_0V8 = 11'h320;
    localparam logic [10:0] MV_1V2 = 11'h4B0;
    // ==========================================
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> verilog/ccr_mf_decode.sv
// multiplier code decoder shared by both pll factor fields
`default_nettype none
module ccr_mf_decode (
    // code in
    input  wire logic [3:0] code,
    // decoded factor
    output logic      [4:0] factor,
    output logic            valid
);
    // ==========================================
    // decode
    always_comb begin
        factor = 5'h00;
        valid  = 1'b1;
        unique case (code)
            4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC: begin
                factor = 5'(code) + 5'h02;
            end
            4'hE: begin
                factor = 5'h10;
            end
            4'hF: begin
                factor = 5'h14;
            end
            // reserved codes: no defined frequency
            default: begin
                valid = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> verilog/ccr_top.sv
// reset and clock configuration registers behind an axi4-lite slave
// ==========================================
// Operation
// - usb full speed peripheral stays in reset while bit 12 of the reset register is one.
// - bit 30 feeds the main pll from the crystal at zero and the 48 mhz rc clock at one.
// - bits 18 and 17 route system clock at zero or twice the third pll output at one.
// - bit 16 picks the crystal-or-rc source at zero or the second pll output at one.
// - bits 15:12 decode 0110..1100 as x8..x14, 1110 as x16, 1111 as x20, others reserved.
// - bits 11:8 use the same multiplier decoding for the second pll.
// - bits 7:4 divide the second predivider input by the field value plus one.
// - bits 3:0 divide the first predivider input by the field value plus one.
// - bit 0 of the first predivider is one storage bit shared with bit 17 of register zero.
// - bit 29 is the top extension bit of the adc clock prescaler.
// - the two-bit field asks for 1.0, 0.9, 0.8 or 1.2 volt core in deep sleep.
// - every register takes byte, half-word and word writes on its strobed lanes only.
// - all three registers reset to zero.
//
// The AXI4-Lite register port was left to the implementer.
`default_nettype none
module ccr_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,

    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,

    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,

    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,

    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,

    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,

    // shared predivider bit, config register zero side
    input  wire logic        cfg0_pdiv_bit_we,
    input  wire logic        cfg0_pdiv_bit_wdata,
    output logic             cfg0_pdiv_bit,

    // peripheral reset
    output logic             usb_full_speed_reset_bit,

    // clock tree controls
    output logic             main_pll_input_select,
    output logic             adc_clock_prescaler_msb,
    output logic             second_audio_clock_select,
    output logic             first_audio_clock_select,
    output logic             first_predivider_input_select,
    output logic [3:0]       third_pll_multiplier,
    output logic [3:0]       second_pll_multiplier,
    output logic [4:0]       third_pll_factor,
    output logic             third_pll_factor_valid,
    output logic [4:0]       second_pll_factor,
    output logic             second_pll_factor_valid,
    output logic [3:0]       second_predivider,
    output logic [4:0]       second_predivider_ratio,
    output logic [3:0]       first_predivider,
    output logic [4:0]       first_predivider_ratio,

    // deep sleep
    output logic [1:0]       deep_sleep_voltage_select,
    output logic [10:0]      deep_sleep_core_millivolts
);
    // ==========================================
    // storage
    logic [31:0] ahb_peripheral_reset;
    logic [31:0] clock_config_one;
    logic [31:0] deep_sleep_core_voltage;

    // ==========================================
    // write channel: address and data held until both present
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire         aw_take    = s_axi_awvalid && s_axi_awready;
    wire         w_take     = s_axi_wvalid && s_axi_wready;
    wire         wr_fire    = aw_held && w_held && !s_axi_bvalid;
    wire  [7:0]  wr_word    = {aw_addr[7:2], 2'b00};
    wire         wr_hit_rst = (wr_word == ccr_pkg::OFF_AHB_RST);
    wire         wr_hit_c1  = (wr_word == ccr_pkg::OFF_CFG1);
    wire         wr_hit_dsv = (wr_word == ccr_pkg::OFF_DSV);
    wire         wr_hit     = wr_hit_rst || wr_hit_c1 || wr_hit_dsv;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;

    // ==========================================
    // byte lane mask from strobes
    logic [31:0] lane_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane_mask[8*gi +: 8] = {8{w_strb[gi]}};
        end
    endgenerate

    wire [31:0] mask_rst = lane_mask & ccr_pkg::MASK_AHB_RST;
    wire [31:0] mask_c1  = lane_mask & ccr_pkg::MASK_CFG1;
    wire [31:0] mask_dsv = lane_mask & ccr_pkg::MASK_DSV;

    // reserved bits never store, so they always read zero
    wire [31:0] next_rst = (ahb_peripheral_reset & ~mask_rst) | (w_data & mask_rst);
    wire [31:0] next_dsv = (deep_sleep_core_voltage & ~mask_dsv) | (w_data & mask_dsv);
    wire [31:0] c1_bus   = (clock_config_one & ~mask_c1) | (w_data & mask_c1);
    wire        c1_bus_we = wr_fire && wr_hit_c1;

    // shared bit: a bus write here and a write from register zero both land on it;
    // if both come in one cycle the bus wins when it strobes lane zero, a choice made for determinism
    logic [31:0] next_c1;
    always_comb begin
        next_c1 = c1_bus_we ? c1_bus : clock_config_one;
        if (cfg0_pdiv_bit_we && !(c1_bus_we && mask_c1[ccr_pkg::PDIV0_LSB])) begin
            next_c1[ccr_pkg::PDIV0_LSB] = cfg0_pdiv_bit_wdata;
        end
    end

    // either channel may come first; each waits in its own holding flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // an unmapped address is answered but stores nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= ccr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bresp <= wr_hit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
        end
    end

    // ==========================================
    // register storage, one short process per register
    wire        rst_we = wr_fire && wr_hit_rst;
    wire        dsv_we = wr_fire && wr_hit_dsv;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ahb_peripheral_reset <= ccr_pkg::RST_AHB_RST;
        end else if (rst_we) begin
            ahb_peripheral_reset <= next_rst;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_config_one <= ccr_pkg::RST_CFG1;
        end else begin
            // side writes may come on any cycle, so this register loads every edge
            clock_config_one <= next_c1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deep_sleep_core_voltage <= ccr_pkg::RST_DSV;
        end else if (dsv_we) begin
            deep_sleep_core_voltage <= next_dsv;
        end
    end

    // ==========================================
    // read channel, one cycle answer
    wire [7:0] rd_word    = {s_axi_araddr[7:2], 2'b00};
    wire       rd_hit_rst = (rd_word == ccr_pkg::OFF_AHB_RST);
    wire       rd_hit_c1  = (rd_word == ccr_pkg::OFF_CFG1);
    wire       rd_hit_dsv = (rd_word == ccr_pkg::OFF_DSV);
    wire       rd_hit     = rd_hit_rst || rd_hit_c1 || rd_hit_dsv;
    wire [31:0] rd_mux    = rd_hit_rst ? ahb_peripheral_reset :
                            rd_hit_c1  ? clock_config_one :
                            rd_hit_dsv ? deep_sleep_core_voltage : 32'h0000_0000;

    assign s_axi_arready = !s_axi_rvalid;
    wire        rd_take  = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // data loads only on a taken address, so it holds while rvalid waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ccr_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
        end
    end

    // ==========================================
    // peripheral reset, straight from storage
    assign usb_full_speed_reset_bit      = ahb_peripheral_reset[ccr_pkg::USB_RST_BIT];

    // ==========================================
    // clock source selects
    assign main_pll_input_select         = clock_config_one[ccr_pkg::PLL_SEL_BIT];
    assign adc_clock_prescaler_msb       = clock_config_one[ccr_pkg::ADC_PSC_BIT];
    assign second_audio_clock_select     = clock_config_one[ccr_pkg::AUD2_SEL_BIT];
    assign first_audio_clock_select      = clock_config_one[ccr_pkg::AUD1_SEL_BIT];
    assign first_predivider_input_select = clock_config_one[ccr_pkg::PDIV0_SEL_BIT];

    // ==========================================
    // multiplier and predivider fields
    assign third_pll_multiplier  = clock_config_one[ccr_pkg::PLL3_MF_LSB +: 4];
    assign second_pll_multiplier = clock_config_one[ccr_pkg::PLL2_MF_LSB +: 4];
    // no pll-enable inputs here, so write ordering is left to software
    assign second_predivider     = clock_config_one[ccr_pkg::PDIV1_LSB +: 4];
    assign first_predivider      = clock_config_one[ccr_pkg::PDIV0_LSB +: 4];
    assign second_predivider_ratio = {1'b0, second_predivider} + 5'h01;
    assign first_predivider_ratio  = {1'b0, first_predivider} + 5'h01;

    // ==========================================
    // shared bit and deep sleep field
    assign cfg0_pdiv_bit         = clock_config_one[ccr_pkg::PDIV0_LSB];
    // only the field is held here; the regulator acts on it in deep sleep alone
    assign deep_sleep_voltage_select = deep_sleep_core_voltage[1:0];

    // ==========================================
    // multiplier decode
    ccr_mf_decode u_mf_third (
        .code   (third_pll_multiplier),
        .factor (third_pll_factor),
        .valid  (third_pll_factor_valid)
    );

    ccr_mf_decode u_mf_second (
        .code   (second_pll_multiplier),
        .factor (second_pll_factor),
        .valid  (second_pll_factor_valid)
    );

    // ==========================================
    // deep sleep voltage request
    always_comb begin
        unique case (deep_sleep_voltage_select)
            ccr_pkg::DSV_1V0: deep_sleep_core_millivolts = ccr_pkg::MV_1V0;
            ccr_pkg::DSV_0V9: deep_sleep_core_millivolts = ccr_pkg::MV_0V9;
            ccr_pkg::DSV_0V8: deep_sleep_core_millivolts = ccr_pkg::MV_0V8;
            ccr_pkg::DSV_1V2: deep_sleep_core_millivolts = ccr_pkg::MV_1V2;
        endcase
    end
endmodule
`default_nettype wire

// >>> tb/ccr_top_asserts.sv
// checker: field decoding and write timing seen at the slice's ports
`default_nettype none
module ccr_top_asserts (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus and shared bit
    input wire logic        s_axi_bvalid,
    input wire logic        cfg0_pdiv_bit_we,
    input wire logic        cfg0_pdiv_bit_wdata,
    input wire logic        cfg0_pdiv_bit,
    // field outputs
    input wire logic        usb_full_speed_reset_bit,
    input wire logic [3:0]  third_pll_multiplier,
    input wire logic [4:0]  third_pll_factor,
    input wire logic        third_pll_factor_valid,
    input wire logic [3:0]  first_predivider,
    input wire logic [4:0]  first_predivider_ratio,
    input wire logic [1:0]  deep_sleep_voltage_select,
    input wire logic [10:0] deep_sleep_core_millivolts
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [10:0] MV_TABLE [4] = '{11'h3E8, 11'h384, 11'h320, 11'h4B0};
    // ==========================================
    // assertions
    default clocking ck @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // the usb reset bit only moves on the edge that raises the write response
    a_usb_bit_hold: assert property (
        $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(usb_full_speed_reset_bit))
        else $error("usb reset bit moved without a write");
    a_reset_clears: assert property (disable iff (1'h0)
        !aresetn |=> !usb_full_speed_reset_bit && deep_sleep_voltage_select == 2'h0
        && first_predivider == 4'h0 && third_pll_multiplier == 4'h0)
        else $error("field not cleared by reset");
    a_code_valid: assert property (
        third_pll_factor_valid == (third_pll_multiplier > 4'h5 && third_pll_multiplier != 4'hD)
        && (third_pll_factor_valid || third_pll_factor == 5'h00))
        else $error("multiplier validity wrong");
    a_code_factor: assert property (third_pll_factor_valid |-> third_pll_factor ==
        (third_pll_multiplier == 4'hE ? 5'h10 : third_pll_multiplier == 4'hF ? 5'h14
        : {1'h0, third_pll_multiplier} + 5'h02)) else $error("multiplier factor wrong");
    a_ratio_plus_one: assert property (
        first_predivider_ratio == {1'h0, first_predivider} + 5'h01) else $error("ratio wrong");
    a_shared_mirror: assert property (cfg0_pdiv_bit == first_predivider[0])
        else $error("shared bit differs");
    // a bus write strobing lane zero on the same edge wins over the side write
    a_shared_write: assert property (cfg0_pdiv_bit_we |=> $rose(s_axi_bvalid)
        || cfg0_pdiv_bit == $past(cfg0_pdiv_bit_wdata)) else $error("shared bit write lost");
    a_sleep_volts: assert property (
        deep_sleep_core_millivolts == MV_TABLE[deep_sleep_voltage_select])
        else $error("core voltage wrong");
    c_write: cover property (s_axi_bvalid);
    c_shared: cover property (cfg0_pdiv_bit_we);
    c_reserved: cover property (third_pll_multiplier == 4'hD && !third_pll_factor_valid);
endmodule
`default_nettype wire

// >>> tb/test_ccr_top.sv
// testbench: registers, field outputs and shared bit of the clock config slice
`default_nettype none
module test_ccr_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // signals
    logic        aclk = 1'h0, aresetn = 1'h0, cfg0_pdiv_bit_we = 1'h0, cfg0_pdiv_bit_wdata = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, third_pll_multiplier, second_pll_multiplier;
    logic [3:0]  second_predivider, first_predivider;
    logic [1:0]  s_axi_bresp, s_axi_rresp, deep_sleep_voltage_select;
    logic [4:0]  third_pll_factor, second_pll_factor, second_predivider_ratio;
    logic [4:0]  first_predivider_ratio;
    logic [10:0] deep_sleep_core_millivolts;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        cfg0_pdiv_bit, usb_full_speed_reset_bit, main_pll_input_select;
    logic        adc_clock_prescaler_msb, second_audio_clock_select, first_audio_clock_select;
    logic        first_predivider_input_select, third_pll_factor_valid, second_pll_factor_valid;
    int          miscompares = 0, total_checks = 0;
    logic [7:0]  regs [3] = '{8'h28, 8'h2C, 8'h34};
    wire  [4:0]  sel_bits = {main_pll_input_select, adc_clock_prescaler_msb,
        second_audio_clock_select, first_audio_clock_select, first_predivider_input_select};
    ccr_top ccr_top_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cfg0_pdiv_bit_we, .cfg0_pdiv_bit_wdata, .cfg0_pdiv_bit,
        .usb_full_speed_reset_bit, .main_pll_input_select, .adc_clock_prescaler_msb,
        .second_audio_clock_select, .first_audio_clock_select, .first_predivider_input_select,
        .third_pll_multiplier, .second_pll_multiplier, .third_pll_factor, .third_pll_factor_valid,
        .second_pll_factor, .second_pll_factor_valid, .second_predivider, .second_predivider_ratio,
        .first_predivider, .first_predivider_ratio, .deep_sleep_voltage_select,
        .deep_sleep_core_millivolts
    );
    always #5 aclk = ~aclk;
    // ==========================================
    // report and compare
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [4:0] fx(input logic [3:0] c);
        if (c == 4'hE) return 5'h10;
        if (c == 4'hF) return 5'h14;
        if (c < 4'h6 || c == 4'hD) return 5'h00;
        return {1'h0, c} + 5'h02;
    endfunction
    // ==========================================
    // one write then a read back of the same word; a write with wstrb of zero stores nothing
    task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er, input logic [31:0] ed);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (n = 0; n < 40 && !(s_axi_rvalid && s_axi_rready); n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) begin
                chk("bresp", 32'(er), 32'(s_axi_bresp));
                s_axi_bready  <= 1'h0;
                s_axi_arvalid <= 1'h1;
                s_axi_rready  <= 1'h1;
            end
        end
        s_axi_rready <= 1'h0;
        chk("answer", 32'h1, 32'(n < 40));
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        if (n == 40) end_sim();
    endtask
    // ==========================================
    // scenarios
    task automatic t_usb;
        foreach (regs[i]) acc(regs[i], 32'h0, 4'h0, 2'h0, 32'h0);
        // bit 12 sits in lane one, so a write without that strobe leaves it zero
        acc(8'h28, 32'h0000_1000, 4'hD, 2'h0, 32'h0);
        acc(8'h28, 32'h0000_1000, 4'h2, 2'h0, 32'h0000_1000);
        chk("usb_reset", 32'h1, 32'(usb_full_speed_reset_bit));
        acc(8'h30, 32'hFFFF_FFFF, 4'hF, 2'h2, 32'h0);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (regs[i]) acc(regs[i], 32'h0, 4'h0, 2'h0, 32'h0);
        chk("usb_reset", 32'h0, 32'(usb_full_speed_reset_bit));
    endtask
    task automatic t_selects;
        int pos [5] = '{30, 29, 18, 17, 16};
        foreach (pos[i]) begin
            acc(8'h2C, 32'h1 << pos[i], 4'hF, 2'h0, 32'h1 << pos[i]);
            chk("selects", 32'h10 >> i, 32'(sel_bits));
        end
    endtask
    task automatic t_fields;
        logic [3:0]  c;
        logic [5:0]  f;
        logic [31:0] v;
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            f = {fx(c), fx(c) != 5'h00};
            v = {16'h0, c, c, c, ~c};
            // no pll is ever enabled here, so predivider writes are legal
            acc(8'h2C, v, 4'hF, 2'h0, v);
            chk("fields", v, {16'h0, third_pll_multiplier, second_pll_multiplier,
                second_predivider, first_predivider});
            chk("pll3", 32'(f), 32'({third_pll_factor, third_pll_factor_valid}));
            chk("pll2", 32'(f), 32'({second_pll_factor, second_pll_factor_valid}));
            chk("ratio2", 32'(c) + 32'h1, 32'(second_predivider_ratio));
            chk("ratio1", {28'h0, ~c} + 32'h1, 32'(first_predivider_ratio));
        end
    endtask
    task automatic t_volts;
        logic [31:0] mv [4] = '{32'h3E8, 32'h384, 32'h320, 32'h4B0};
        foreach (mv[j]) begin
            acc(8'h34, 32'(j), 4'h1, 2'h0, 32'(j));
            chk("dsv_field", 32'(j), 32'(deep_sleep_voltage_select));
            chk("millivolts", mv[j], 32'(deep_sleep_core_millivolts));
        end
        acc(8'h2C, 32'h6007_2211, 4'hC, 2'h0, 32'h6007_FFF0);
        acc(8'h2C, 32'h6007_2211, 4'h1, 2'h0, 32'h6007_FF11);
    endtask
    task automatic t_shared;
        acc(8'h2C, 32'h0, 4'h1, 2'h0, 32'h6007_FF00);
        cfg0_pdiv_bit_we    <= 1'h1;
        cfg0_pdiv_bit_wdata <= 1'h1;
        @(posedge aclk);
        cfg0_pdiv_bit_we <= 1'h0;
        acc(8'h2C, 32'h0, 4'h0, 2'h0, 32'h6007_FF01);
        chk("shared_bit", 32'h1, 32'(cfg0_pdiv_bit));
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_usb();
        t_selects();
        t_fields();
        t_volts();
        t_shared();
        end_sim();
    end
endmodule
bind ccr_top ccr_top_asserts ccr_top_asserts_i (.aclk, .aresetn, .s_axi_bvalid,
    .cfg0_pdiv_bit_we, .cfg0_pdiv_bit_wdata, .cfg0_pdiv_bit, .usb_full_speed_reset_bit,
    .third_pll_multiplier, .third_pll_factor, .third_pll_factor_valid, .first_predivider,
    .first_predivider_ratio, .deep_sleep_voltage_select, .deep_sleep_core_millivolts);
`default_nettype wire
